// file: verilog/mpo_seq.sv
/*
 Low-power reset sequencer: reset inputs, refresh control in the low-power
 state, system reset output, PLL gating, termination and preset outputs.
 Assumes all inputs synchronous to sys_clk and an Avalon-MM master on the bus.
*/
// The Avalon-MM register port was chosen for this implementation.
// Functional notes
// - Misc register bit 2 enables refresh in low power; default cleared, off.
// - Low-power refresh type is the one configured before power-good fell.
// - Master reset sampled low clears the low-power refresh enable bit.
// - Power-good reset leaves the refresh enable bit unchanged.
// - Self-refresh exit issues exactly one CBR cycle, then normal CBR refresh.
// - Low-power refresh runs on the 32 kHz tick.
// - System reset output asserts when core and I/O supplies present and either reset asserted.
// - While reset, PLL clocks gated and CPU held; release follows PLL timer.
// - Master reset returns registers to defaults, PLL timer to 4 ms.
// - Cold boot holds reset output until both reset inputs deassert.
// - Low power keeps programmed PLL timer and gates the PLLs.
// - Power-good assertion asserts reset output at once, held in low power while I/O supply is up.
// - On exit, reset output driven once I/O supply returns, until timer expires.
// - Pull-down termination active unless both reset inputs high.
// - General outputs two and three may drive preset values in low power.
// - Power-good release runs power-up sequence without resetting clock or RAM flag.
// - Master reset fully resets clock unit and sets RAM invalid flag.
`timescale 1ns/10ps
module mpo_seq #(
   parameter int TICK_DIV = mpo_pkg::TICK_DIV_DEF
) (
   input  wire logic                        sys_clk,
   input  wire logic                        srst,
   input  wire logic [mpo_pkg::ADDR_W-1:0]  avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [3:0]                  avs_byteenable,
   input  wire logic [31:0]                 avs_writedata,
   output logic      [31:0]                 avs_readdata,
   output logic                             avs_waitrequest,
   input  wire logic                        masterResetInN,
   input  wire logic                        powerGoodResetInN,
   input  wire logic                        coreSupplyOk,
   input  wire logic                        systemIoSupplyOk,
   input  wire logic                        gpTwoNormal,
   input  wire logic                        gpThreeNormal,
   output logic                             systemResetOut,
   output logic                             coreHold,
   output logic                             forceTerm,
   output logic                             generalOutputTwo,
   output logic                             generalOutputThree,
   output logic                             refreshPulse,
   output logic                             selfRefreshOut,
   output logic                             normalRefreshOn,
   output logic                             rtcFullReset,
   output logic                             lowPowerActive
);
   import mpo_pkg::*;

   logic [DIV_W-1:0]     divCnt;
   logic                 tick;
   logic                 mrMeta;
   logic                 mrSync;
   logic                 pgMeta;
   logic                 pgSync;
   logic                 mrAsserted;
   logic                 pgAsserted;
   mpo_state_t           state;
   logic [PLL_CNT_W-1:0] pllCnt;
   logic [PLL_CNT_W-1:0] pllLimit;
   logic                 lpSelfRef;
   logic [7:0]           clockControl;
   logic [7:0]           miscPower;
   logic                 rtcRamInvalid;
   logic                 busWr;
   logic                 wrClock;
   logic                 wrMisc;
   logic                 wrStatus;
   logic                 internalRst;
   logic                 lpOn;
   logic [7:0]           next_readByte;

   // ------------------------------------------------------------------
   // Slow tick divider
   // ------------------------------------------------------------------
   // 32 kHz enable
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         divCnt <= '0;
         tick   <= 1'b0;
      end
      else if (divCnt == DIV_W'(TICK_DIV - 1))
      begin
         divCnt <= '0;
         tick   <= 1'b1;
      end
      else
      begin
         divCnt <= divCnt + DIV_W'(1);
         tick   <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Reset input synchronisers
   // ------------------------------------------------------------------
   // Two stages on tick
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         mrMeta <= 1'b0;
         mrSync <= 1'b0;
         pgMeta <= 1'b0;
         pgSync <= 1'b0;
      end
      else if (tick)
      begin
         mrMeta <= masterResetInN;
         mrSync <= mrMeta;
         pgMeta <= powerGoodResetInN;
         pgSync <= pgMeta;
      end
   end

   assign mrAsserted = ~mrSync;
   assign pgAsserted = ~pgSync;
   assign lpOn       = miscPower[MISC_LP_REFRESH];
   assign pllLimit   = PLL_BASE_CNT << clockControl[CLK_PLL_LO +: CLK_PLL_W];

   // ------------------------------------------------------------------
   // Power sequencer
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state     <= ST_COLD;
         pllCnt    <= '0;
         lpSelfRef <= 1'b0;
      end
      else if (tick)
      begin
         if (mrAsserted)
         begin
            state  <= ST_COLD;
            pllCnt <= '0;
         end
         else
         begin
            unique case (state)
               ST_COLD:
                  if (!pgAsserted)
                  begin
                     state  <= ST_PLLWAIT;
                     pllCnt <= '0;
                  end
               ST_RUN:
                  if (pgAsserted)
                  begin
                     state     <= ST_LOWPWR;
                     lpSelfRef <= miscPower[MISC_SELF_REF];
                  end
               ST_LOWPWR:
                  if (!pgAsserted)
                  begin
                     state  <= ST_PLLWAIT;
                     pllCnt <= '0;
                  end
               ST_PLLWAIT:
                  if (pgAsserted)
                     state <= ST_LOWPWR;
                  else if (pllCnt >= pllLimit - PLL_CNT_W'(1))
                     state <= ST_RUN;
                  else
                     pllCnt <= pllCnt + PLL_CNT_W'(1);
            endcase
         end
      end
   end

   // ------------------------------------------------------------------
   // Refresh control
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         refreshPulse    <= 1'b0;
         selfRefreshOut  <= 1'b0;
         normalRefreshOn <= 1'b0;
      end
      else
      begin
         refreshPulse    <= 1'b0;
         normalRefreshOn <= (state == ST_RUN);
         if (tick)
         begin
            if (state == ST_LOWPWR && lpOn && !lpSelfRef)
               refreshPulse <= 1'b1;
            if (selfRefreshOut && state == ST_LOWPWR && !pgAsserted && !mrAsserted)
            begin
               refreshPulse   <= 1'b1;
               selfRefreshOut <= 1'b0;
            end
            else
               selfRefreshOut <= (state == ST_LOWPWR) && lpOn && lpSelfRef;
         end
      end
   end

   // ------------------------------------------------------------------
   // Reset, hold, termination and preset outputs
   // ------------------------------------------------------------------
   // Core supply and either reset, or sequencer out of run state
   assign internalRst = coreSupplyOk &
                        (~masterResetInN | ~powerGoodResetInN | (state != ST_RUN));

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         systemResetOut <= 1'b1;
         coreHold       <= 1'b1;
         lowPowerActive <= 1'b0;
      end
      else
      begin
         // Driven only while I/O supply is up
         systemResetOut <= internalRst & systemIoSupplyOk;
         coreHold       <= internalRst;
         lowPowerActive <= (state == ST_LOWPWR);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         forceTerm <= 1'b1;
      else if (tick)
         forceTerm <= ~(mrSync & pgSync);
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         generalOutputTwo   <= 1'b0;
         generalOutputThree <= 1'b0;
      end
      else
      begin
         generalOutputTwo <= (state == ST_LOWPWR && miscPower[MISC_GP2_EN]) ?
                             miscPower[MISC_GP2_VAL] : gpTwoNormal;
         generalOutputThree <= (state == ST_LOWPWR && miscPower[MISC_GP3_EN]) ?
                               miscPower[MISC_GP3_VAL] : gpThreeNormal;
      end
   end

   // ------------------------------------------------------------------
   // Clock unit reset and RAM flag
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rtcFullReset  <= 1'b1;
         rtcRamInvalid <= 1'b1;
      end
      else
      begin
         rtcFullReset <= mrAsserted;
         if (mrAsserted)
            rtcRamInvalid <= 1'b1;
         else if (wrStatus && avs_writedata[STAT_RAM_INVAL])
            rtcRamInvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Avalon-MM slave
   // ------------------------------------------------------------------
   assign busWr    = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign wrClock  = busWr & (avs_address == ADR_CLOCK_CONTROL);
   assign wrMisc   = busWr & (avs_address == ADR_MISC_POWER);
   assign wrStatus = busWr & (avs_address == ADR_STATUS);

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst || mrAsserted)
      begin
         clockControl <= CLOCK_CONTROL_RST;
         miscPower    <= MISC_POWER_RST;
      end
      else
      begin
         if (wrClock)
            clockControl <= avs_writedata[7:0];
         if (wrMisc)
            miscPower <= avs_writedata[7:0];
      end
   end

   always_comb
   begin
      next_readByte = 8'h00;
      unique case (avs_address)
         ADR_CLOCK_CONTROL: next_readByte = clockControl;
         ADR_MISC_POWER:    next_readByte = miscPower;
         ADR_STATUS:        next_readByte = {5'h00, systemResetOut, rtcRamInvalid,
                                             lowPowerActive};
         default:           next_readByte = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
         avs_readdata <= 32'h0000_0000;
      else if (avs_read && avs_waitrequest)
         avs_readdata <= {24'h00_0000, next_readByte};
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_refresh_disabled: assert property (
      (state == ST_LOWPWR && !lpOn) |=> !refreshPulse || $past(selfRefreshOut))
      else $error("refresh active while disabled");
   a_type_capture: assert property (
      (tick && state == ST_RUN && pgAsserted && !mrAsserted)
      |=> state == ST_LOWPWR && lpSelfRef == $past(miscPower[MISC_SELF_REF]))
      else $error("refresh type not captured");
   a_master_clears: assert property (
      mrAsserted |=> !miscPower[MISC_LP_REFRESH] && clockControl == CLOCK_CONTROL_RST)
      else $error("master reset left config");
   a_pg_keeps_bit: assert property (
      (!mrAsserted && !wrMisc && $changed(pgSync)) |=> $stable(miscPower))
      else $error("power-good changed refresh bit");
   a_exit_kick: assert property (
      ($past(selfRefreshOut) && !selfRefreshOut && state != ST_COLD) |-> refreshPulse
      ##1 !refreshPulse)
      else $error("no single kick on self-refresh exit");
   a_tick_refresh: assert property (
      refreshPulse |-> $past(tick))
      else $error("refresh off the slow tick");
   a_reset_assert: assert property (
      (coreSupplyOk && systemIoSupplyOk && (!masterResetInN || !powerGoodResetInN))
      |=> systemResetOut && coreHold)
      else $error("reset output not asserted");
   a_hold_gate: assert property (
      (coreSupplyOk && state != ST_RUN) |=> coreHold)
      else $error("clocks not gated in reset");
   a_cold_hold: assert property (
      (tick && state == ST_COLD && pgAsserted) |=> state == ST_COLD)
      else $error("cold boot released early");
   a_lowpwr_timer: assert property (
      (state == ST_LOWPWR && !wrClock && !mrAsserted) |=> $stable(clockControl))
      else $error("timer lost in low power");
   a_exit_drive: assert property (
      (state == ST_PLLWAIT && coreSupplyOk && systemIoSupplyOk) |=> systemResetOut)
      else $error("reset output dropped before timer");
   a_term_table: assert property (
      ($past(tick) && !$past(mrSync)) |-> forceTerm)
      else $error("termination off with master low");
   a_gp_preset: assert property (
      $past(state == ST_LOWPWR && miscPower[MISC_GP2_EN])
      |-> generalOutputTwo == $past(miscPower[MISC_GP2_VAL]))
      else $error("preset output wrong");
   a_rtc_kept: assert property (
      (!mrAsserted && state == ST_PLLWAIT) |=> !rtcFullReset)
      else $error("clock unit reset by power-good");
   a_rtc_full: assert property (
      $rose(mrAsserted) |=> rtcFullReset && rtcRamInvalid)
      else $error("master reset missed clock unit");
   a_sync_hold: assert property (
      !tick |=> $stable(mrSync) && $stable(pgSync))
      else $error("sync moved without tick");
   a_pll_count: assert property (
      (tick && state == ST_PLLWAIT && !pgAsserted && !mrAsserted
       && pllCnt < pllLimit - PLL_CNT_W'(1)) |=> state == ST_PLLWAIT)
      else $error("reset released before count");

   c_enter_low: cover property (state == ST_RUN ##1 state == ST_LOWPWR);
   c_self_exit: cover property ($fell(selfRefreshOut) && refreshPulse);
   c_cold_run: cover property (state == ST_PLLWAIT ##1 state == ST_RUN);
   c_bus_write: cover property (wrMisc);

endmodule // mpo_seq

// file: verilog/mpo_pkg.sv
/*
 Constants, register map and state type of the low-power reset sequencer.
 Assumes a 200 MHz system clock and a 32768 Hz oscillator rate for the slow domain.
*/
package mpo_pkg;

   // ------------------------------------------------------------------
   // Clock rates and divider
   // ------------------------------------------------------------------
   localparam int SYS_CLK_HZ   = 200_000_000;
   localparam int OSC_HZ       = 32768;
   localparam int TICK_DIV_DEF = SYS_CLK_HZ / OSC_HZ;
   localparam int DIV_W        = 13;

   // ------------------------------------------------------------------
   // PLL start-up timer, counted in slow ticks
   // ------------------------------------------------------------------
   localparam int PLL_BASE_MS    = 4;
   localparam int PLL_BASE_TICKS = (PLL_BASE_MS * OSC_HZ + 999) / 1000;
   localparam int PLL_CNT_W      = 12;
   localparam logic [PLL_CNT_W-1:0] PLL_BASE_CNT = PLL_CNT_W'(PLL_BASE_TICKS);
   localparam int CLK_PLL_LO     = 0;
   localparam int CLK_PLL_W      = 2;

   // ------------------------------------------------------------------
   // Register indices and byte addresses
   // ------------------------------------------------------------------
   localparam int ADDR_W          = 10;
   localparam logic [7:0] IDX_CLOCK_CONTROL = 8'h8f;
   localparam logic [7:0] IDX_MISC_POWER    = 8'hba;
   localparam logic [7:0] IDX_STATUS        = 8'hbb;
   localparam logic [ADDR_W-1:0] ADR_CLOCK_CONTROL = {IDX_CLOCK_CONTROL, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_MISC_POWER    = {IDX_MISC_POWER, 2'h0};
   localparam logic [ADDR_W-1:0] ADR_STATUS        = {IDX_STATUS, 2'h0};

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int MISC_SELF_REF   = 0;
   localparam int MISC_LP_REFRESH = 2;
   localparam int MISC_GP2_VAL    = 3;
   localparam int MISC_GP3_VAL    = 4;
   localparam int MISC_GP2_EN     = 5;
   localparam int MISC_GP3_EN     = 6;
   localparam int STAT_LOW_POWER  = 0;
   localparam int STAT_RAM_INVAL  = 1;
   localparam int STAT_SYS_RESET  = 2;
   localparam logic [7:0] CLOCK_CONTROL_RST = 8'h00;
   localparam logic [7:0] MISC_POWER_RST    = 8'h00;

   // ------------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {ST_COLD, ST_RUN, ST_LOWPWR, ST_PLLWAIT} mpo_state_t;

endpackage

// file: bench/mpo_board_model.sv
/*
 Board-side model: reset sources, supply flags and a counter of refresh requests.
 Assumes the testbench calls its tasks one at a time from a single process.
*/
`timescale 1ns/10ps
module mpo_board_model (
   input  wire logic sys_clk,
   input  wire logic refreshPulse,
   output logic      masterResetInN,
   output logic      powerGoodResetInN,
   output logic      coreSupplyOk,
   output logic      systemIoSupplyOk,
   output int        refreshCount
);
   // ---------------------------------------------------------------
   // Power-on state: core up, both resets asserted
   // ---------------------------------------------------------------
   initial
   begin
      masterResetInN = 1'b0;
      powerGoodResetInN = 1'b0;
      coreSupplyOk = 1'b1;
      systemIoSupplyOk = 1'b1;
   end
   // ---------------------------------------------------------------
   // DRAM side: count refresh requests
   // ---------------------------------------------------------------
   always @(posedge sys_clk)
      if (refreshPulse === 1'b1)
         refreshCount <= refreshCount + 1;
   // ---------------------------------------------------------------
   // Reset sources and I/O supply
   // ---------------------------------------------------------------
   // Shared source, long pulses
   task automatic setResets(input logic m, input logic pg);
      @(posedge sys_clk);
      masterResetInN <= m;
      powerGoodResetInN <= pg;
   endtask
   task automatic enterLowPower;
      @(posedge sys_clk);
      powerGoodResetInN <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic dropIo(input int hold);
      repeat (hold) @(posedge sys_clk);
      systemIoSupplyOk <= 1'b0;
   endtask
   task automatic exitLowPower;
      @(posedge sys_clk);
      systemIoSupplyOk <= 1'b1;
      @(posedge sys_clk);
      powerGoodResetInN <= 1'b1;
   endtask
endmodule // mpo_board_model

// file: bench/test_micro_power_off_reset_sequencer.sv
/*
 Testbench of the low-power reset sequencer: registers, cold boot, low power, refresh.
 Assumes mpo_board_model drives the reset and supply inputs.
*/
`timescale 1ns/10ps
module test_micro_power_off_reset_sequencer;
   import mpo_pkg::*;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   localparam int TDIV = 4;
   logic              sys_clk, srst, avs_read, avs_write, gp2N, gp3N;
   logic [ADDR_W-1:0] avs_address;
   logic [31:0]       avs_writedata, avs_readdata;
   logic              avs_waitrequest, mRstN, pgN, coreOk, ioOk;
   logic              sysRst, coreHold, forceTerm, gpTwo, gpThree;
   logic              refreshPulse, selfRef, normRef, rtcRst, lowPwr;
   int                n_mismatch = 0;
   int                compares = 0;
   int                r0;
   wire  logic [3:0]  mon = {selfRef, normRef, sysRst, lowPwr};

   mpo_seq #(.TICK_DIV(TDIV)) i_dut (.sys_clk(sys_clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(4'h1), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .masterResetInN(mRstN), .powerGoodResetInN(pgN),
      .coreSupplyOk(coreOk), .systemIoSupplyOk(ioOk), .gpTwoNormal(gp2N),
      .gpThreeNormal(gp3N), .systemResetOut(sysRst), .coreHold(coreHold),
      .forceTerm(forceTerm), .generalOutputTwo(gpTwo), .generalOutputThree(gpThree),
      .refreshPulse(refreshPulse), .selfRefreshOut(selfRef), .normalRefreshOn(normRef),
      .rtcFullReset(rtcRst), .lowPowerActive(lowPwr));
   mpo_board_model i_board (.sys_clk(sys_clk), .refreshPulse(refreshPulse),
      .masterResetInN(mRstN), .powerGoodResetInN(pgN), .coreSupplyOk(coreOk),
      .systemIoSupplyOk(ioOk), .refreshCount());

   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, seen);
         n_mismatch++;
      end
   endtask
   task automatic pause(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic waitSig(input int sel, input logic val);
      for (int k = 0; k < 3000; k++)
      begin
         pause(1);
         if (mon[sel] === val)
            return;
      end
      check("wait timeout", 8'(sel), 8'hff);
      report_and_stop;
   endtask
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      int k;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= wr;
      avs_read <= ~wr;
      for (k = 0; k < 100; k++)
      begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0)
            break;
      end
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k == 100)
      begin
         check("bus timeout", 8'h0, 8'hff);
         report_and_stop;
      end
   endtask
   task automatic busWr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic busChk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      check("register", q, exp);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic testRegDefaults;
      busChk(ADR_MISC_POWER, MISC_POWER_RST);
      busWr(ADR_CLOCK_CONTROL, 8'hff);
      busChk(ADR_CLOCK_CONTROL, CLOCK_CONTROL_RST);
      busChk(ADR_STATUS, 8'h06);
      busChk(10'h000, 8'h00);
   endtask
   task automatic testColdBoot;
      check("reset out", sysRst, 1'b1);
      i_board.setResets(1'b1, 1'b0);
      pause(24);
      check("termination", forceTerm, 1'b1);
      check("reset out", sysRst, 1'b1);
      i_board.setResets(1'b0, 1'b1);
      pause(24);
      check("termination", forceTerm, 1'b1);
      check("reset out", sysRst, 1'b1);
      i_board.setResets(1'b1, 1'b1);
      pause(24);
      check("termination", forceTerm, 1'b0);
      pause(400);
      check("reset out", sysRst, 1'b1);
      check("core hold", coreHold, 1'b1);
      waitSig(1, 1'b0);
      check("core hold", coreHold, 1'b0);
      check("normal refresh", normRef, 1'b1);
      busWr(ADR_STATUS, 8'h02);
      busChk(ADR_STATUS, 8'h00);
      busWr(ADR_CLOCK_CONTROL, 8'h01);
      busChk(ADR_CLOCK_CONTROL, 8'h01);
   endtask
   task automatic testLowPowerCbr;
      busWr(ADR_MISC_POWER, 8'h2c);
      i_board.enterLowPower;
      #1;
      check("reset out", sysRst, 1'b1);
      i_board.dropIo(30);
      waitSig(0, 1'b1);
      check("core hold", coreHold, 1'b1);
      check("general two", gpTwo, 1'b1);
      check("general three", gpThree, 1'b1);
      r0 = i_board.refreshCount;
      pause(40);
      check("refresh count", 8'(i_board.refreshCount - r0), 8'd10);
      i_board.exitLowPower;
      #1;
      check("reset out", sysRst, 1'b1);
      pause(700);
      check("reset out", sysRst, 1'b1);
      waitSig(1, 1'b0);
      busChk(ADR_MISC_POWER, 8'h2c);
      busChk(ADR_STATUS, 8'h00);
   endtask
   task automatic testSelfRefresh;
      busWr(ADR_MISC_POWER, 8'h05);
      i_board.enterLowPower;
      i_board.dropIo(30);
      waitSig(3, 1'b1);
      busWr(ADR_MISC_POWER, 8'h04);
      r0 = i_board.refreshCount;
      pause(40);
      check("refresh count", 8'(i_board.refreshCount - r0), 8'd0);
      i_board.exitLowPower;
      waitSig(3, 1'b0);
      waitSig(2, 1'b1);
      check("exit refresh", 8'(i_board.refreshCount - r0), 8'd1);
   endtask
   task automatic testMasterClear;
      busWr(ADR_MISC_POWER, 8'h04);
      i_board.setResets(1'b0, 1'b1);
      pause(24);
      check("clock unit reset", rtcRst, 1'b1);
      busChk(ADR_MISC_POWER, 8'h00);
      busChk(ADR_STATUS, 8'h06);
      i_board.setResets(1'b1, 1'b1);
      waitSig(1, 1'b0);
      i_board.enterLowPower;
      i_board.dropIo(30);
      waitSig(0, 1'b1);
      r0 = i_board.refreshCount;
      pause(40);
      check("refresh count", 8'(i_board.refreshCount - r0), 8'd0);
      i_board.exitLowPower;
      waitSig(1, 1'b0);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      srst = 1'b1;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = '0;
      avs_writedata = '0;
      gp2N = 1'b0;
      gp3N = 1'b1;
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      testRegDefaults;
      testColdBoot;
      testLowPowerCbr;
      testSelfRefresh;
      testMasterClear;
      report_and_stop;
   end
endmodule // test_micro_power_off_reset_sequencer
